// ===== pkg/tes_regs.vh
// Register map and field layout of the 424 kbit/s edge shaping block
// How it works
// - Firmware codes 1,2,3 give one, two or three linear ramps; codes 0 and 7 to 15 reserved.
// - Table codes 4,5,6: plain, supply-adapted corrected, supply-adapted uncorrected.
// - Type byte: falling style in upper nibble, rising style in lower nibble.
// - Falling firmware style: falling style field is the time constant.
// - Falling table style: falling style field selects one of four tables.
// - Rising firmware style: rising style field is the time constant.
// - Rising table style: rising style field selects one of four tables.
// - Length scaling bit: state lasts one carrier cycle, or two when set.
// - Five-bit count sets transition states for both edges.
// - Style bits 7 and 3, length bits 6:5 are reserved.
`ifndef TES_REGS_VH
`define TES_REGS_VH
// ----------------------------------------
// Word indices, byte address is four times the index
// ----------------------------------------
`define TES_TYPE_IDX 11'h517
`define TES_STYLE_IDX 11'h518
`define TES_LENGTH_IDX 11'h519
`define TES_CTRL_IDX 11'h520
`define TES_STAT_IDX 11'h524
// ----------------------------------------
// Fields and codes
// ----------------------------------------
`define TES_STYLE_MASK 8'h77
`define TES_LENGTH_MASK 8'h9f
`define TES_LEN_SCALE_BIT 7
`define TES_FW_ONE 4'h1
`define TES_FW_THREE 4'h3
`define TES_LUT_PLAIN 4'h4
`define TES_LUT_CORR 4'h5
`define TES_LUT_NOCORR 4'h6
`define TES_RESET_BYTE 8'h00
`endif

// ===== core/tes_edge_shaper.v
// Edge shaping sequencer with AXI4-Lite configuration registers
`timescale 1ns/100ps
`include "tes_regs.vh"
module tes_edge_shaper (
    // Clock and reset
    input wire clk_i,
    input wire rst_i,
    // AXI4-Lite slave
    input wire [12:0] s_axi_awaddr_i,
    input wire s_axi_awvalid_i,
    output wire s_axi_awready_o,
    input wire [31:0] s_axi_wdata_i,
    input wire [3:0] s_axi_wstrb_i,
    input wire s_axi_wvalid_i,
    output wire s_axi_wready_o,
    output reg [1:0] s_axi_bresp_o,
    output reg s_axi_bvalid_o,
    input wire s_axi_bready_i,
    input wire [12:0] s_axi_araddr_i,
    input wire s_axi_arvalid_i,
    output wire s_axi_arready_o,
    output reg [31:0] s_axi_rdata_o,
    output reg [1:0] s_axi_rresp_o,
    output reg s_axi_rvalid_o,
    input wire s_axi_rready_i,
    // Modulation request and driver side
    input wire mod_edge_i,
    output reg shaping_active_o,
    output reg edge_falling_o,
    output reg [1:0] ramp_count_o,
    output reg [2:0] time_const_o,
    output reg lut_mode_o,
    output reg [1:0] lut_sel_o,
    output reg supply_adapt_o,
    output reg supply_corr_o,
    output reg [4:0] state_index_o
);
    // ----------------------------------------
    // Registers
    // ----------------------------------------
    reg [7:0] type_reg;
    reg [7:0] style_reg;
    reg [7:0] length_reg;
    reg aw_seen_reg;
    reg w_seen_reg;
    reg [12:0] awaddr_reg;
    reg [31:0] wdata_reg;
    reg [3:0] wstrb_reg;
    reg mod_q1_reg;
    reg mod_q2_reg;
    reg mod_q3_reg;
    reg mod_level_reg;
    reg half_reg;
    reg reserved_type_reg;
    wire aw_go = s_axi_awvalid_i && s_axi_awready_o;
    wire w_go = s_axi_wvalid_i && s_axi_wready_o;
    wire [12:0] wa = aw_go ? s_axi_awaddr_i : awaddr_reg;
    wire [31:0] wd = w_go ? s_axi_wdata_i : wdata_reg;
    wire [3:0] ws = w_go ? s_axi_wstrb_i : wstrb_reg;
    wire do_write = (aw_seen_reg || aw_go) && (w_seen_reg || w_go) && !s_axi_bvalid_o;
    assign s_axi_awready_o = !aw_seen_reg && !s_axi_bvalid_o;
    assign s_axi_wready_o = !w_seen_reg && !s_axi_bvalid_o;
    assign s_axi_arready_o = !s_axi_rvalid_o;
    // ----------------------------------------
    // Write channel
    // ----------------------------------------
    always @(posedge clk_i) begin
        if (rst_i) begin
            type_reg <= `TES_RESET_BYTE;
            style_reg <= `TES_RESET_BYTE;
            length_reg <= `TES_RESET_BYTE;
            aw_seen_reg <= 1'b0;
            w_seen_reg <= 1'b0;
            awaddr_reg <= 13'h0000;
            wdata_reg <= 32'h00000000;
            wstrb_reg <= 4'h0;
            s_axi_bvalid_o <= 1'b0;
            s_axi_bresp_o <= 2'b00;
        end else begin
            if (aw_go) begin
                awaddr_reg <= s_axi_awaddr_i;
                aw_seen_reg <= 1'b1;
            end
            if (w_go) begin
                wdata_reg <= s_axi_wdata_i;
                wstrb_reg <= s_axi_wstrb_i;
                w_seen_reg <= 1'b1;
            end
            if (do_write) begin
                aw_seen_reg <= 1'b0;
                w_seen_reg <= 1'b0;
                s_axi_bvalid_o <= 1'b1;
                s_axi_bresp_o <= 2'b00;
                // Each byte register sits in the low lane of its own word
                // Offsets are word indices, so no two registers share a word
                if (wa[12:2] == `TES_TYPE_IDX) begin
                    if (ws[0]) type_reg <= wd[7:0];
                end else if (wa[12:2] == `TES_STYLE_IDX) begin
                    if (ws[0]) style_reg <= wd[7:0];
                end else if (wa[12:2] == `TES_LENGTH_IDX) begin
                    if (ws[0]) length_reg <= wd[7:0];
                end else if (wa[12:2] != `TES_STAT_IDX) begin
                    s_axi_bresp_o <= 2'b10;
                end
            end else if (s_axi_bvalid_o && s_axi_bready_i) begin
                s_axi_bvalid_o <= 1'b0;
            end
        end
    end
    // ----------------------------------------
    // Read channel
    // ----------------------------------------
    always @(posedge clk_i) begin
        if (rst_i) begin
            s_axi_rvalid_o <= 1'b0;
            s_axi_rdata_o <= 32'h00000000;
            s_axi_rresp_o <= 2'b00;
        end else if (s_axi_arvalid_i && s_axi_arready_o) begin
            s_axi_rvalid_o <= 1'b1;
            s_axi_rresp_o <= 2'b00;
            s_axi_rdata_o <= 32'h00000000;
            if (s_axi_araddr_i[12:2] == `TES_TYPE_IDX)
                s_axi_rdata_o <= {24'h000000, type_reg};
            else if (s_axi_araddr_i[12:2] == `TES_STYLE_IDX)
                s_axi_rdata_o <= {24'h000000, style_reg};
            else if (s_axi_araddr_i[12:2] == `TES_LENGTH_IDX)
                s_axi_rdata_o <= {24'h000000, length_reg};
            // Status: 13 reserved code, 12 active, 11 falling, 10 table, 4:0 state
            else if (s_axi_araddr_i[12:2] == `TES_STAT_IDX)
                s_axi_rdata_o <= {18'h00000, reserved_type_reg, shaping_active_o,
                    edge_falling_o, lut_mode_o, 5'h00, state_index_o};
            else
                s_axi_rresp_o <= 2'b10;
        end else if (s_axi_rvalid_o && s_axi_rready_i) begin
            s_axi_rvalid_o <= 1'b0;
        end
    end
    // ----------------------------------------
    // Edge decode
    // ----------------------------------------
    reg [3:0] code;
    reg [2:0] fld;
    reg code_fw;
    reg code_lut;
    always @* begin
        code = 4'h0;
        fld = 3'h0;
        if (!mod_q3_reg) begin
            code = type_reg[7:4];
            fld = style_reg[6:4];
        end else begin
            code = type_reg[3:0];
            fld = style_reg[2:0];
        end
        code_fw = (code >= `TES_FW_ONE) && (code <= `TES_FW_THREE);
        code_lut = (code >= `TES_LUT_PLAIN) && (code <= `TES_LUT_NOCORR);
    end
    // ----------------------------------------
    // Transition sequencer
    // ----------------------------------------
    // Three stages because the request comes from the modulator pin
    always @(posedge clk_i) begin
        if (rst_i) begin
            // Stages start at the idle high level: no false edge on release
            mod_q1_reg <= 1'b1;
            mod_q2_reg <= 1'b1;
            mod_q3_reg <= 1'b1;
            mod_level_reg <= 1'b1;
            half_reg <= 1'b0;
            reserved_type_reg <= 1'b0;
            shaping_active_o <= 1'b0;
            edge_falling_o <= 1'b0;
            ramp_count_o <= 2'b00;
            time_const_o <= 3'h0;
            lut_mode_o <= 1'b0;
            lut_sel_o <= 2'b00;
            supply_adapt_o <= 1'b0;
            supply_corr_o <= 1'b0;
            state_index_o <= 5'h00;
        end else begin
            mod_q1_reg <= mod_edge_i;
            mod_q2_reg <= mod_q1_reg;
            mod_q3_reg <= mod_q2_reg;
            if (mod_q2_reg == mod_q3_reg && mod_q3_reg != mod_level_reg) begin
                // New edge restarts the pattern; low level means falling edge
                mod_level_reg <= mod_q3_reg;
                edge_falling_o <= !mod_q3_reg;
                half_reg <= 1'b0;
                state_index_o <= 5'h00;
                reserved_type_reg <= !(code_fw || code_lut);
                ramp_count_o <= code_fw ? code[1:0] : 2'b00;
                lut_mode_o <= code_lut;
                supply_adapt_o <= code_lut && (code != `TES_LUT_PLAIN);
                supply_corr_o <= code == `TES_LUT_CORR;
                time_const_o <= code_fw ? fld : 3'h0;
                lut_sel_o <= code_lut ? fld[1:0] : 2'b00;
                // Zero count means no shaped edge
                shaping_active_o <= (code_fw || code_lut) && (length_reg[4:0] != 5'h00);
            end else if (shaping_active_o) begin
                // Double length holds each state two cycles
                if (length_reg[`TES_LEN_SCALE_BIT] && !half_reg) begin
                    half_reg <= 1'b1;
                end else begin
                    half_reg <= 1'b0;
                    if (state_index_o + 5'h01 >= length_reg[4:0])
                        shaping_active_o <= 1'b0;
                    else
                        state_index_o <= state_index_o + 5'h01;
                end
            end
        end
    end
endmodule // tes_edge_shaper

// ===== bench/tes_edge_shaper_chk.sv
// Port checker for the edge shaper
`timescale 1ns/100ps
module tes_edge_shaper_chk (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Read channel
    input wire logic s_axi_arvalid_i,
    input wire logic s_axi_arready_o,
    input wire logic s_axi_rvalid_o,
    // Driver side
    input wire logic shaping_active_o,
    input wire logic lut_mode_o,
    input wire logic [1:0] ramp_count_o,
    input wire logic [2:0] time_const_o,
    input wire logic supply_adapt_o,
    input wire logic supply_corr_o,
    input wire logic [4:0] state_index_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    fw_ramp_a: assert property (shaping_active_o && !lut_mode_o |-> ramp_count_o != 2'h0)
        else $error("firmware edge without ramps");
    lut_tc_a: assert property (lut_mode_o |-> ramp_count_o == 2'h0 && time_const_o == 3'h0)
        else $error("table edge shows firmware fields");
    supply_mode_a: assert property (supply_adapt_o || supply_corr_o |-> lut_mode_o && supply_adapt_o)
        else $error("supply adaptation outside table mode");
    start_idx_a: assert property ($rose(shaping_active_o) |-> state_index_o == 5'h00)
        else $error("pattern does not start at state zero");
    step_idx_a: assert property (shaping_active_o && $past(shaping_active_o)
        && state_index_o != 5'h00 |-> state_index_o - $past(state_index_o) <= 5'h01)
        else $error("state index jumped");
    state_hold_a: assert property (shaping_active_o && $past(shaping_active_o)
        && $stable(state_index_o) |=> !shaping_active_o || $changed(state_index_o))
        else $error("state lasted over two cycles");
    rd_resp_a: assert property (s_axi_arvalid_i && s_axi_arready_o |=> s_axi_rvalid_o)
        else $error("read answer late");
    rd_busy_a: assert property (s_axi_rvalid_o |-> !s_axi_arready_o)
        else $error("read taken while answer pending");
endmodule // tes_edge_shaper_chk
bind tes_edge_shaper tes_edge_shaper_chk u_chk (.*);

// ===== bench/tes_rf_drv.sv
// Driver model: applies modulation level, times each shaped edge
`timescale 1ns/100ps
module tes_rf_drv (
    // Clock and request
    input wire logic clk_i,
    input wire logic level_i,
    // Shaper side
    input wire logic active_i,
    output logic mod_edge_o,
    output logic [6:0] run_len_o
);
    logic [6:0] cnt = 7'h00;
    assign mod_edge_o = level_i;
    always @(posedge clk_i) begin
        cnt <= active_i ? cnt + 7'h01 : 7'h00;
        if (!active_i && cnt != 7'h00) run_len_o <= cnt;
    end
endmodule // tes_rf_drv

// ===== bench/tes_edge_shaper_tb.sv
// Register and edge pattern tests for the edge shaper
`timescale 1ns/100ps
module tes_edge_shaper_tb;
    localparam logic [15:0] I_TYPE = 16'h0517, I_STY = 16'h0518, I_LEN = 16'h0519;
    localparam logic [15:0] I_STAT = 16'h0524;
    localparam logic [12:0] A_TYPE = 13'(I_TYPE * 4), A_STY = 13'(I_STY * 4);
    localparam logic [12:0] A_LEN = 13'(I_LEN * 4), A_STAT = 13'(I_STAT * 4);
    logic clk_i = 0, rst_i = 1, lvl = 1, s_axi_awvalid_i = 0, s_axi_wvalid_i = 0;
    logic s_axi_bready_i = 0, s_axi_arvalid_i = 0, s_axi_rready_i = 0;
    logic [12:0] s_axi_awaddr_i = 0, s_axi_araddr_i = 0;
    logic [31:0] s_axi_wdata_i = 0, rdat;
    logic [3:0] s_axi_wstrb_i = 4'hf;
    logic [1:0] resp;
    wire s_axi_awready_o, s_axi_wready_o, s_axi_arready_o, s_axi_bvalid_o, s_axi_rvalid_o;
    wire shaping_active_o, edge_falling_o, lut_mode_o, supply_adapt_o, supply_corr_o, mod_edge_i;
    wire [1:0] s_axi_bresp_o, s_axi_rresp_o, ramp_count_o, lut_sel_o;
    wire [2:0] time_const_o;
    wire [4:0] state_index_o;
    wire [6:0] run_len;
    wire [31:0] s_axi_rdata_o;
    int n_fail = 0, samples_checked = 0, elen, i;
    tes_edge_shaper dut (.*);
    tes_rf_drv drv (.clk_i(clk_i), .level_i(lvl), .active_i(shaping_active_o),
        .mod_edge_o(mod_edge_i), .run_len_o(run_len));
    initial forever #2 clk_i = ~clk_i;
    task chk(string nm, logic [31:0] s, logic [31:0] e);
        samples_checked++;
        if (s !== e) begin
            n_fail++;
            $display("MISMATCH %s expected %h seen %h", nm, e, s);
        end
    endtask
    // Handshakes are judged mid-cycle, acted on at the next rising edge
    task bus(input logic w, input logic [12:0] a, input logic [7:0] d);
        logic aw, wd, ar, hs;
        @(posedge clk_i);
        s_axi_awaddr_i <= a;
        s_axi_araddr_i <= a;
        s_axi_wdata_i <= {24'h0, d};
        s_axi_awvalid_i <= w;
        s_axi_wvalid_i <= w;
        s_axi_bready_i <= w;
        s_axi_arvalid_i <= !w;
        s_axi_rready_i <= !w;
        hs = 0;
        while (!hs) begin
            @(negedge clk_i);
            aw = s_axi_awready_o;
            wd = s_axi_wready_o;
            ar = s_axi_arready_o;
            hs = w ? s_axi_bvalid_o : s_axi_rvalid_o;
            rdat = s_axi_rdata_o;
            resp = w ? s_axi_bresp_o : s_axi_rresp_o;
            @(posedge clk_i);
            if (aw) s_axi_awvalid_i <= 1'b0;
            if (wd) s_axi_wvalid_i <= 1'b0;
            if (ar) s_axi_arvalid_i <= 1'b0;
        end
        s_axi_bready_i <= 1'b0;
        s_axi_rready_i <= 1'b0;
    endtask
    task shape(input logic lv, input logic [3:0] c, input logic [2:0] f);
        int n;
        logic ok;
        ok = c inside {[4'h1:4'h6]};
        @(posedge clk_i);
        lvl <= lv;
        for (n = 0; n < 20 && !shaping_active_o; n++) @(negedge clk_i);
        chk("active", shaping_active_o, ok);
        if (ok) begin
            chk("falling", edge_falling_o, !lv);
            chk("ramps", ramp_count_o, c < 4 ? c : 0);
            chk("table", {lut_mode_o, supply_adapt_o, supply_corr_o}, {c > 3, c > 4, c == 5});
            chk("timeconst", time_const_o, c < 4 ? f : 0);
            chk("tablesel", lut_sel_o, c > 3 ? f[1:0] : 0);
            for (n = 0; n < 90 && shaping_active_o; n++) @(negedge clk_i);
            @(negedge clk_i);
            chk("length", run_len, elen);
        end
    endtask
    task report_and_stop;
        $display("checks %0d mismatches %0d", samples_checked, n_fail);
        if (n_fail == 0 && samples_checked > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial begin
        repeat (4) @(posedge clk_i);
        rst_i <= 1'b0;
        bus(0, A_TYPE, 8'h00);
        chk("type reset", rdat, 0);
        bus(0, 13'h0000, 8'h00);
        chk("unmapped", resp, 2'b10);
        // Reserved bits set on purpose: they must not alter the pattern
        bus(1, A_LEN, 8'he3);
        bus(1, A_STY, 8'h8d);
        bus(0, A_LEN, 8'h00);
        chk("length reg", rdat, 32'he3);
        bus(0, A_STY, 8'h00);
        chk("style reg", rdat, 32'h8d);
        elen = 6;
        for (i = 1; i < 8; i++) begin
            bus(1, A_TYPE, {i[3:0], 4'(7 - i)});
            shape(0, i[3:0], 3'h0);
            shape(1, 4'(7 - i), 3'h5);
        end
        // Last edge was rising with a reserved code: only the reserved flag stands
        bus(0, A_STAT, 8'h00);
        chk("status", rdat, 32'h00002000);
        bus(1, A_LEN, 8'h1f);
        bus(1, A_TYPE, 8'h33);
        elen = 31;
        shape(0, 4'h3, 3'h0);
        report_and_stop;
    end
    initial begin
        #200000;
        n_fail++;
        report_and_stop;
    end
endmodule // tes_edge_shaper_tb
